//--- common/ctx_pkg.sv
package ctx_pkg;
	// ====================================================
	// opcodes handled here
	localparam logic [7:0] OP_TEST_FIRST = 8'h72;
	localparam logic [7:0] OP_TEST_LAST  = 8'h77;
	localparam logic [7:0] OP_WTEST_RR   = 8'h78;
	localparam logic [7:0] OP_WTEST_LIT  = 8'h79;
	localparam logic [7:0] OP_TRAP       = 8'hf2;
	localparam logic [7:0] OP_XOR_FIRST  = 8'hb2;
	localparam logic [7:0] OP_XOR_LAST   = 8'hb7;
	localparam logic [7:0] OP_WXOR_RR    = 8'hb8;
	localparam logic [7:0] OP_WXOR_LIT   = 8'hb9;
	// low nibble selects the operand form
	localparam logic [3:0] FORM_RR       = 4'h2;
	localparam logic [3:0] FORM_RIR      = 4'h3;
	localparam logic [3:0] FORM_R8R8     = 4'h4;
	localparam logic [3:0] FORM_R8IR     = 4'h5;
	localparam logic [3:0] FORM_R8IM     = 4'h6;
	localparam logic [3:0] FORM_IRIM     = 4'h7;
	localparam logic [3:0] FORM_XRR      = 4'h8;
	localparam logic [3:0] FORM_XIM      = 4'h9;
	localparam logic [3:0] WORK_PAGE_NIB = 4'he;
	// fetch lengths and documented cycle counts
	localparam logic [2:0] LEN_TWO       = 3'h2;
	localparam logic [2:0] LEN_THREE     = 3'h3;
	localparam logic [2:0] LEN_WIDE      = 3'h4;
	localparam logic [3:0] CYC_THREE     = 4'h3;
	localparam logic [3:0] CYC_FOUR      = 4'h4;
	localparam logic [3:0] CYC_TRAP      = 4'h6;
	// flag byte layout
	localparam int FLG_C = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_S = 5;
	localparam int FLG_V = 4;
	localparam int FLG_D = 3;
	localparam int FLG_H = 2;
	localparam logic [15:0] TRAP_PC_DEC  = 16'h0002;
	localparam logic [15:0] TRAP_FLG_DEC = 16'h0001;
	localparam logic [15:0] NEXT_BYTE    = 16'h0001;

	// ====================================================
	// types
	typedef enum logic [1:0] {CLS_NONE, CLS_TEST, CLS_XOR, CLS_TRAP} ctx_cls_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_SPTR, ST_SRC, ST_DPTR, ST_DST,
		ST_PCL, ST_FLG, ST_VHI, ST_VLO, ST_VEND, ST_PAIRH, ST_PAIRL
	} ctx_state_t;
	typedef struct packed {
		ctx_cls_t    cls;
		logic        srcImm;
		logic        srcInd;
		logic        dstInd;
		logic [11:0] srcAddr;
		logic [11:0] dstAddr;
		logic [7:0]  imm;
		logic [2:0]  len;
		logic [3:0]  cycles;
	} ctx_dec_t;
	typedef struct packed {
		logic        req;
		logic        we;
		logic        prog;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ctx_mem_t;

	// ====================================================
	// helpers
	function automatic logic [11:0] workAddr(input logic [7:0] base, input logic [3:0] nib);
		return {base, nib};
	endfunction
	// an 8-bit register in the working page maps onto the working set
	function automatic logic [11:0] regAddr(input logic [7:0] base, input logic [7:0] r);
		return (r[7:4] == WORK_PAGE_NIB) ? workAddr(base, r[3:0]) : {4'h0, r};
	endfunction
	function automatic logic [15:0] signExt8(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction
	function automatic ctx_mem_t memRd(input logic prog, input logic [15:0] a);
		return '{req: 1'b1, we: 1'b0, prog: prog, addr: a, wdata: 8'h00};
	endfunction
	function automatic ctx_mem_t memWr(input logic [15:0] a, input logic [7:0] d);
		return '{req: 1'b1, we: 1'b1, prog: 1'b0, addr: a, wdata: d};
	endfunction
	function automatic logic [7:0] flagsFor(input logic [7:0] prior, input logic [7:0] res);
		logic [7:0] f;
		f = prior;
		f[FLG_Z] = (res == 8'h00);
		f[FLG_S] = res[7];
		f[FLG_V] = 1'b0;
		return f;
	endfunction
endpackage

//--- verilog/ctx_decode.sv
`timescale 1ns/10ps
module ctx_decode (
	input  wire logic [7:0]      opcode,   // opcode byte
	input  wire logic [7:0]      op1,      // first operand byte
	input  wire logic [7:0]      op2,      // second operand byte
	input  wire logic [7:0]      op3,      // third operand byte
	input  wire logic [7:0]      workBase, // working set base, addr bits 11:4
	output ctx_pkg::ctx_dec_t    dec       // decoded instruction
);
	// ====================================================
	// class
	wire logic [3:0] form    = opcode[3:0];
	wire logic       isTest  = (opcode >= ctx_pkg::OP_TEST_FIRST && opcode <= ctx_pkg::OP_TEST_LAST)
	                         || opcode == ctx_pkg::OP_WTEST_RR || opcode == ctx_pkg::OP_WTEST_LIT;
	wire logic       isXor   = (opcode >= ctx_pkg::OP_XOR_FIRST && opcode <= ctx_pkg::OP_XOR_LAST)
	                         || opcode == ctx_pkg::OP_WXOR_RR || opcode == ctx_pkg::OP_WXOR_LIT;
	wire logic       isTrap  = (opcode == ctx_pkg::OP_TRAP);
	wire logic [11:0] wideSrc = {op1, op2[7:4]};
	wire logic [11:0] wideDst = {op2[3:0], op3};

	// ====================================================
	// operand fields, length and cycles per form
	always_comb begin
		dec = '0;
		dec.cls = isTrap ? ctx_pkg::CLS_TRAP : isTest ? ctx_pkg::CLS_TEST :
		          isXor ? ctx_pkg::CLS_XOR : ctx_pkg::CLS_NONE;
		if (isTrap) begin
			dec.imm    = op1;
			dec.len    = ctx_pkg::LEN_TWO;
			dec.cycles = ctx_pkg::CYC_TRAP;
		end else if (isTest || isXor) begin
			unique case (form)
				ctx_pkg::FORM_RR: begin
					dec.dstAddr = ctx_pkg::workAddr(workBase, op1[7:4]);
					dec.srcAddr = ctx_pkg::workAddr(workBase, op1[3:0]);
					dec.len = ctx_pkg::LEN_TWO;   dec.cycles = ctx_pkg::CYC_THREE;
				end
				ctx_pkg::FORM_RIR: begin
					dec.dstAddr = ctx_pkg::workAddr(workBase, op1[7:4]);
					dec.srcAddr = ctx_pkg::workAddr(workBase, op1[3:0]);
					dec.srcInd = 1'b1;
					dec.len = ctx_pkg::LEN_TWO;   dec.cycles = ctx_pkg::CYC_FOUR;
				end
				ctx_pkg::FORM_R8R8, ctx_pkg::FORM_R8IR: begin
					dec.srcAddr = ctx_pkg::regAddr(workBase, op1);
					dec.dstAddr = ctx_pkg::regAddr(workBase, op2);
					dec.srcInd = (form == ctx_pkg::FORM_R8IR);
					dec.len = ctx_pkg::LEN_THREE;
					dec.cycles = dec.srcInd ? ctx_pkg::CYC_FOUR : ctx_pkg::CYC_THREE;
				end
				ctx_pkg::FORM_R8IM, ctx_pkg::FORM_IRIM: begin
					dec.dstAddr = ctx_pkg::regAddr(workBase, op1);
					dec.imm = op2;
					dec.srcImm = 1'b1;
					dec.dstInd = (form == ctx_pkg::FORM_IRIM);
					dec.len = ctx_pkg::LEN_THREE;
					dec.cycles = dec.dstInd ? ctx_pkg::CYC_FOUR : ctx_pkg::CYC_THREE;
				end
				ctx_pkg::FORM_XRR: begin
					dec.srcAddr = wideSrc;
					dec.dstAddr = wideDst;
					dec.len = ctx_pkg::LEN_WIDE;  dec.cycles = ctx_pkg::CYC_THREE;
				end
				default: begin // FORM_XIM, the only one left in range
					dec.imm = op1;
					dec.srcImm = 1'b1;
					dec.dstAddr = wideDst;
					dec.len = ctx_pkg::LEN_WIDE;  dec.cycles = ctx_pkg::CYC_THREE;
				end
			endcase
		end
	end
endmodule

//--- verilog/ctx_exec.sv
`timescale 1ns/10ps
// Functional notes
// - opcodes 72-77: AND operands, no write, Z/S from result, V cleared
// - opcodes 78/79: wide-address AND test, same flags, four fetch bytes
// - trap pushes PC at SP-2, then flags at one below
// - F2 plus vector: after pushes load PC from vector location, flags unchanged
// - opcodes B2-B7: XOR written to destination, Z/S from result, V cleared
// - opcodes B8/B9: wide-address XOR stored to wide destination
// - result flags follow outcome, unaffected flags kept, cleared flags zero
// - displacement byte is sign-extended before adding to base
// - pointer pair: two working registers form a sixteen-bit address
module ctx_exec (
	input  wire logic              ref_clk,     // cpu clock
	input  wire logic              sys_rst,     // async reset, high
	input  wire logic              instrValid,  // instruction bytes present
	input  wire logic [7:0]        opcode,      // opcode byte
	input  wire logic [7:0]        op1,         // operand byte 1
	input  wire logic [7:0]        op2,         // operand byte 2
	input  wire logic [7:0]        op3,         // operand byte 3
	input  wire logic [7:0]        workBase,    // working set base
	input  wire logic [15:0]       pcIn,        // address of next instruction
	input  wire logic [15:0]       spIn,        // current stack pointer
	input  wire logic [7:0]        flagsIn,     // current flags
	input  wire logic [7:0]        memRdata,    // read data, same cycle as request
	input  wire logic              pairReq,     // pointer pair lookup request
	input  wire logic [2:0]        pairSel,     // working pair index
	input  wire logic [15:0]       dispBase,    // base for displacement add
	input  wire logic [7:0]        dispByte,    // signed displacement
	output ctx_pkg::ctx_mem_t      memReq,      // memory request, one cycle
	output logic                   busy,        // not accepting work
	output logic                   done,        // instruction finished pulse
	output logic                   illegal,     // opcode not of this group
	output logic                   lenValid,    // length fields valid pulse
	output logic [2:0]             instrLen,    // bytes to advance PC
	output logic [3:0]             instrCycles, // documented cycle count
	output logic [7:0]             flagsOut,    // new flags
	output logic                   flagsWe,     // flags write pulse
	output logic [15:0]            spOut,       // new stack pointer
	output logic                   spWe,        // stack pointer write pulse
	output logic [15:0]            pcOut,       // new program counter
	output logic                   pcWe,        // program counter write pulse
	output logic [15:0]            pairPtr,     // pointer read from pair
	output logic                   pairDone,    // pair pointer valid pulse
	output logic [15:0]            dispAddr     // base plus displacement
);
	typedef struct packed {
		ctx_pkg::ctx_state_t state;
		ctx_pkg::ctx_dec_t   dec;
		logic [7:0]          srcVal;
		logic [11:0]         dstEff;
		logic [15:0]         spWork;
		logic [7:0]          vecHi;
		ctx_pkg::ctx_mem_t   mem;
		logic                done;
		logic                illegal;
		logic                lenValid;
		logic [2:0]          instrLen;
		logic [3:0]          instrCycles;
		logic [7:0]          flagsOut;
		logic                flagsWe;
		logic [15:0]         spOut;
		logic                spWe;
		logic [15:0]         pcOut;
		logic                pcWe;
		logic [15:0]         pairPtr;
		logic                pairDone;
		logic                busy;
	} ctx_regs_t;

	ctx_regs_t          regsQ;
	ctx_regs_t          regsD;
	ctx_pkg::ctx_dec_t  dec;
	logic [15:0]        dispAddrQ;

	ctx_decode u_decode (
		.opcode   (opcode),
		.op1      (op1),
		.op2      (op2),
		.op3      (op3),
		.workBase (workBase),
		.dec      (dec)
	);

	// ====================================================
	// selection
	wire logic              idle     = (regsQ.state == ctx_pkg::ST_IDLE);
	wire logic              accept   = idle && instrValid;
	wire ctx_pkg::ctx_dec_t dstSel   = idle ? dec : regsQ.dec;
	wire ctx_pkg::ctx_state_t dstNext = dstSel.dstInd ? ctx_pkg::ST_DPTR : ctx_pkg::ST_DST;
	wire logic              isXor    = (regsQ.dec.cls == ctx_pkg::CLS_XOR);
	wire logic [7:0]        aluRes   = isXor ? (regsQ.srcVal ^ memRdata)
	                                         : (regsQ.srcVal & memRdata);
	wire logic [15:0]       pairAddr = {4'h0, ctx_pkg::workAddr(workBase, {pairSel, 1'b0})};
	wire logic [15:0]       vecAddr  = {8'h00, regsQ.dec.imm};

	// ====================================================
	// sequencing
	always_comb begin
		regsD          = regsQ;
		regsD.mem      = '0;
		regsD.done     = 1'b0;
		regsD.illegal  = 1'b0;
		regsD.lenValid = 1'b0;
		regsD.flagsWe  = 1'b0;
		regsD.spWe     = 1'b0;
		regsD.pcWe     = 1'b0;
		regsD.pairDone = 1'b0;
		unique case (regsQ.state)
			ctx_pkg::ST_IDLE: begin
				if (instrValid) begin
					regsD.dec         = dec;
					regsD.lenValid    = 1'b1;
					regsD.instrLen    = dec.len;
					regsD.instrCycles = dec.cycles;
					if (dec.cls == ctx_pkg::CLS_NONE) begin
						regsD.illegal = 1'b1;
					end else if (dec.cls == ctx_pkg::CLS_TRAP) begin
						regsD.spWork = spIn - ctx_pkg::TRAP_PC_DEC;
						regsD.mem    = ctx_pkg::memWr(spIn - ctx_pkg::TRAP_PC_DEC, pcIn[15:8]);
						regsD.state  = ctx_pkg::ST_PCL;
					end else if (dec.srcInd) begin
						regsD.mem   = ctx_pkg::memRd(1'b0, {4'h0, dec.srcAddr});
						regsD.state = ctx_pkg::ST_SPTR;
					end else if (dec.srcImm) begin
						regsD.srcVal = dec.imm;
						regsD.dstEff = dstSel.dstAddr;
						regsD.mem    = ctx_pkg::memRd(1'b0, {4'h0, dstSel.dstAddr});
						regsD.state  = dstNext;
					end else begin
						regsD.mem   = ctx_pkg::memRd(1'b0, {4'h0, dec.srcAddr});
						regsD.state = ctx_pkg::ST_SRC;
					end
				end else if (pairReq) begin
					regsD.mem   = ctx_pkg::memRd(1'b0, pairAddr);
					regsD.state = ctx_pkg::ST_PAIRH;
				end
			end
			ctx_pkg::ST_SPTR: begin
				regsD.mem   = ctx_pkg::memRd(1'b0, {8'h00, memRdata});
				regsD.state = ctx_pkg::ST_SRC;
			end
			ctx_pkg::ST_SRC: begin
				regsD.srcVal = memRdata;
				regsD.dstEff = dstSel.dstAddr;
				regsD.mem    = ctx_pkg::memRd(1'b0, {4'h0, dstSel.dstAddr});
				regsD.state  = dstNext;
			end
			ctx_pkg::ST_DPTR: begin
				regsD.dstEff = {4'h0, memRdata};
				regsD.mem    = ctx_pkg::memRd(1'b0, {8'h00, memRdata});
				regsD.state  = ctx_pkg::ST_DST;
			end
			ctx_pkg::ST_DST: begin
				regsD.flagsOut = ctx_pkg::flagsFor(flagsIn, aluRes);
				regsD.flagsWe  = 1'b1;
				// test forms discard the AND value; only XOR stores
				if (isXor) begin
					regsD.mem = ctx_pkg::memWr({4'h0, regsQ.dstEff}, aluRes);
				end
				regsD.done  = 1'b1;
				regsD.state = ctx_pkg::ST_IDLE;
			end
			ctx_pkg::ST_PCL: begin
				regsD.mem   = ctx_pkg::memWr(regsQ.spWork + ctx_pkg::NEXT_BYTE, pcIn[7:0]);
				regsD.state = ctx_pkg::ST_FLG;
			end
			ctx_pkg::ST_FLG: begin
				regsD.spWork = regsQ.spWork - ctx_pkg::TRAP_FLG_DEC;
				regsD.mem    = ctx_pkg::memWr(regsQ.spWork - ctx_pkg::TRAP_FLG_DEC, flagsIn);
				regsD.spOut  = regsQ.spWork - ctx_pkg::TRAP_FLG_DEC;
				regsD.spWe   = 1'b1;
				regsD.state  = ctx_pkg::ST_VHI;
			end
			ctx_pkg::ST_VHI: begin
				regsD.mem   = ctx_pkg::memRd(1'b1, vecAddr);
				regsD.state = ctx_pkg::ST_VLO;
			end
			ctx_pkg::ST_VLO: begin
				regsD.vecHi = memRdata;
				regsD.mem   = ctx_pkg::memRd(1'b1, vecAddr + ctx_pkg::NEXT_BYTE);
				regsD.state = ctx_pkg::ST_VEND;
			end
			ctx_pkg::ST_VEND: begin
				regsD.pcOut = {regsQ.vecHi, memRdata};
				regsD.pcWe  = 1'b1;
				regsD.done  = 1'b1;
				regsD.state = ctx_pkg::ST_IDLE;
			end
			ctx_pkg::ST_PAIRH: begin
				regsD.pairPtr[15:8] = memRdata;
				regsD.mem   = ctx_pkg::memRd(1'b0, pairAddr + ctx_pkg::NEXT_BYTE);
				regsD.state = ctx_pkg::ST_PAIRL;
			end
			ctx_pkg::ST_PAIRL: begin
				regsD.pairPtr[7:0] = memRdata;
				regsD.pairDone     = 1'b1;
				regsD.state        = ctx_pkg::ST_IDLE;
			end
		endcase
		regsD.busy = (regsD.state != ctx_pkg::ST_IDLE);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regsQ <= '0;
		end else begin
			regsQ <= regsD;
		end
	end

	// registered so address arithmetic never sits on the caller's path
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dispAddrQ <= '0;
		end else begin
			dispAddrQ <= dispBase + ctx_pkg::signExt8(dispByte);
		end
	end

	// ====================================================
	// outputs
	assign memReq      = regsQ.mem;
	assign busy        = regsQ.busy;
	assign done        = regsQ.done;
	assign illegal     = regsQ.illegal;
	assign lenValid    = regsQ.lenValid;
	assign instrLen    = regsQ.instrLen;
	assign instrCycles = regsQ.instrCycles;
	assign flagsOut    = regsQ.flagsOut;
	assign flagsWe     = regsQ.flagsWe;
	assign spOut       = regsQ.spOut;
	assign spWe        = regsQ.spWe;
	assign pcOut       = regsQ.pcOut;
	assign pcWe        = regsQ.pcWe;
	assign pairPtr     = regsQ.pairPtr;
	assign pairDone    = regsQ.pairDone;
	assign dispAddr    = dispAddrQ;

	// ====================================================
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	wire logic inDstTest = (regsQ.state == ctx_pkg::ST_DST) && (regsQ.dec.cls == ctx_pkg::CLS_TEST);
	wire logic inDstXor  = (regsQ.state == ctx_pkg::ST_DST) && isXor;
	wire logic trapGo    = accept && (dec.cls == ctx_pkg::CLS_TRAP);

	chk_test_no_store: assert property (inDstTest |=> !memReq.we && flagsWe)
		else $error("bit test wrote memory or skipped flags");
	chk_zero_sign: assert property ((inDstTest || inDstXor) |=>
		flagsOut[ctx_pkg::FLG_Z] == ($past(aluRes) == 8'h00) && !flagsOut[ctx_pkg::FLG_V]
		&& flagsOut[ctx_pkg::FLG_S] == $past(aluRes[7]))
		else $error("zero, sign or overflow flag wrong");
	chk_flags_kept: assert property (flagsWe |->
		flagsOut[ctx_pkg::FLG_C] == $past(flagsIn[ctx_pkg::FLG_C])
		&& flagsOut[ctx_pkg::FLG_D] == $past(flagsIn[ctx_pkg::FLG_D])
		&& flagsOut[ctx_pkg::FLG_H] == $past(flagsIn[ctx_pkg::FLG_H]))
		else $error("carry, decimal or half-carry changed");
	chk_xor_store: assert property (inDstXor |=> memReq.we
		&& memReq.wdata == ($past(regsQ.srcVal) ^ $past(memRdata))
		&& memReq.addr == {4'h0, $past(regsQ.dstEff)})
		else $error("exclusive-or result not stored");
	chk_wide_len: assert property (accept && (opcode == ctx_pkg::OP_WXOR_LIT
		|| opcode == ctx_pkg::OP_WTEST_RR) |=> lenValid && instrLen == ctx_pkg::LEN_WIDE)
		else $error("wide form length wrong");
	chk_trap_pc_push: assert property (trapGo |=> memReq.we
		&& memReq.addr == $past(spIn) - ctx_pkg::TRAP_PC_DEC
		&& memReq.wdata == $past(pcIn[15:8])
		##2 memReq.we && spWe && spOut == memReq.addr)
		else $error("trap stack pushes out of order");
	chk_trap_pc_load: assert property (trapGo |=> !pcWe [*5] ##1 pcWe && done)
		else $error("trap program counter load mistimed");
	chk_trap_no_flags: assert property (trapGo |=> !flagsWe [*6])
		else $error("trap changed flags");
	chk_disp_sign: assert property ($past(dispByte) == 8'hff |->
		dispAddr == $past(dispBase) - 16'h0001)
		else $error("displacement not sign extended");
	chk_pair_read: assert property (idle && !instrValid && pairReq |=> memReq.addr == pairAddr
		##2 pairDone)
		else $error("pointer pair lookup wrong");

	cov_trap: cover property (trapGo ##6 pcWe);
	cov_xor_store: cover property (inDstXor ##1 memReq.we);
	cov_test_ind: cover property (accept && dec.srcInd && dec.cls == ctx_pkg::CLS_TEST);
	cov_pair: cover property (pairDone);
endmodule

//--- verif/ctx_mem_model.sv
`timescale 1ns/10ps
module ctx_mem_model (
	input  wire logic             ref_clk,  // cpu clock
	input  wire ctx_pkg::ctx_mem_t memReq,  // request from block
	output logic [7:0]            memRdata  // read data, same cycle as request
);
	// ==========
	// storage
	logic [7:0] dataMem [0:65535];
	logic [7:0] progMem [0:65535];
	logic [7:0] lastRd;
	wire logic       rdReq  = memReq.req && !memReq.we;
	wire logic [7:0] rdByte = memReq.prog ? progMem[memReq.addr] : dataMem[memReq.addr];
	initial begin
		lastRd = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			dataMem[i] = 8'h00;
			progMem[i] = 8'h00;
		end
	end
	// ==========
	// responder
	// block samples the byte at the edge that ends its request cycle
	// idle cycles show the inverse of the last reply so a stale byte never passes
	assign memRdata = rdReq ? rdByte : ~lastRd;
	always @(posedge ref_clk) begin
		if (memReq.req && memReq.we)
			dataMem[memReq.addr] <= memReq.wdata;
		if (rdReq)
			lastRd <= rdByte;
	end
endmodule

//--- verif/tb.sv
`timescale 1ns/10ps
module tb;
	// ==========
	// signals
	logic              ref_clk, sys_rst, instrValid, pairReq;
	logic [7:0]        opcode, op1, op2, op3, workBase, flagsIn, memRdata, dispByte;
	logic [15:0]       pcIn, spIn, dispBase;
	logic [2:0]        pairSel;
	ctx_pkg::ctx_mem_t memReq;
	logic              busy, done, illegal, lenValid, flagsWe, spWe, pcWe, pairDone;
	logic [2:0]        instrLen, gotLen;
	logic [3:0]        instrCycles, gotCyc;
	logic [7:0]        flagsOut, gotFlg;
	logic [15:0]       spOut, pcOut, pairPtr, dispAddr;
	logic              sawFlg, sawIll, sawDone, sawBusy;
	int                err_count = 0;
	int                comparisons = 0;
	int                cycles = 0;

	ctx_exec i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instrValid(instrValid),
		.opcode(opcode), .op1(op1), .op2(op2), .op3(op3), .workBase(workBase),
		.pcIn(pcIn), .spIn(spIn), .flagsIn(flagsIn), .memRdata(memRdata),
		.pairReq(pairReq), .pairSel(pairSel), .dispBase(dispBase), .dispByte(dispByte),
		.memReq(memReq), .busy(busy), .done(done), .illegal(illegal), .lenValid(lenValid),
		.instrLen(instrLen), .instrCycles(instrCycles), .flagsOut(flagsOut),
		.flagsWe(flagsWe), .spOut(spOut), .spWe(spWe), .pcOut(pcOut), .pcWe(pcWe),
		.pairPtr(pairPtr), .pairDone(pairDone), .dispAddr(dispAddr));
	ctx_mem_model i_mem (.ref_clk(ref_clk), .memReq(memReq), .memRdata(memRdata));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========
	// shared tasks
	task automatic complete_run;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic idle;
		for (int k = 0; k < 50; k++) begin
			#1;
			if (busy === 1'b0)
				break;
			@(posedge ref_clk);
		end
	endtask
	task automatic run(input logic [7:0] opc, o1, o2, o3, fl);
		sawFlg = 1'b0;
		sawIll = 1'b0;
		sawDone = 1'b0;
		sawBusy = 1'b0;
		idle();
		@(posedge ref_clk);
		instrValid <= 1'b1;
		{opcode, op1, op2, op3} <= {opc, o1, o2, o3};
		flagsIn <= fl;
		@(posedge ref_clk);
		instrValid <= 1'b0;
		for (int k = 0; k < 20 && !sawDone && !sawIll; k++) begin
			#1;
			if (lenValid === 1'b1)
				{gotLen, gotCyc} = {instrLen, instrCycles};
			if (flagsWe === 1'b1)
				{sawFlg, gotFlg} = {1'b1, flagsOut};
			sawIll = sawIll | (illegal === 1'b1);
			sawBusy = sawBusy | (busy === 1'b1);
			sawDone = (done === 1'b1);
			@(posedge ref_clk);
		end
		// a hang here shows as one mismatch rather than a stall
		if (!sawDone && !sawIll)
			chk("done", 16'h0001, 16'h0000);
		// let the final write land before callers look at memory
		#1;
	endtask
	task automatic alu(input logic [7:0] opc, o1, o2, o3, fl, ef,
		input logic [15:0] a, input logic [7:0] ev);
		run(opc, o1, o2, o3, fl);
		chk("flags", 16'(ef), 16'(gotFlg));
		chk("busy", 16'h0001, 16'(sawBusy));
		chk("dest", 16'(ev), 16'(i_mem.dataMem[a]));
	endtask
	// ==========
	// scenarios
	task automatic t_xor;
		i_mem.dataMem[16'h0101] = 8'h5a;
		i_mem.dataMem[16'h0102] = 8'hc3;
		alu(8'hb2, 8'h12, 8'h00, 8'h00, 8'h9f, 8'haf, 16'h0101, 8'h99);
		i_mem.dataMem[16'h0345] = 8'h7f;
		alu(8'hb9, 8'hff, 8'h03, 8'h45, 8'h00, 8'h20, 16'h0345, 8'h80);
		i_mem.dataMem[16'h0104] = 8'h50;
		i_mem.dataMem[16'h0050] = 8'h0f;
		alu(8'hb7, 8'he4, 8'hf0, 8'h00, 8'h00, 8'h20, 16'h0050, 8'hff);
	endtask
	task automatic t_test;
		i_mem.dataMem[16'h0020] = 8'h0f;
		i_mem.dataMem[16'h0103] = 8'hf0;
		alu(8'h74, 8'h20, 8'he3, 8'h00, 8'h10, 8'h40, 16'h0103, 8'hf0);
		i_mem.dataMem[16'h0123] = 8'h81;
		i_mem.dataMem[16'h0456] = 8'h80;
		alu(8'h78, 8'h12, 8'h34, 8'h56, 8'hc0, 8'ha0, 16'h0456, 8'h80);
	endtask
	task automatic t_trap;
		idle();
		@(posedge ref_clk);
		pcIn <= 16'h1234;
		spIn <= 16'h0200;
		i_mem.progMem[16'h0040] = 8'hab;
		i_mem.progMem[16'h0041] = 8'hcd;
		run(8'hf2, 8'h40, 8'h00, 8'h00, 8'ha4);
		chk("pc hi", 16'h0012, 16'(i_mem.dataMem[16'h01fe]));
		chk("pc lo", 16'h0034, 16'(i_mem.dataMem[16'h01ff]));
		chk("flag push", 16'h00a4, 16'(i_mem.dataMem[16'h01fd]));
		chk("sp", 16'h01fd, spOut);
		chk("pc", 16'habcd, pcOut);
		chk("flag write", 16'h0000, 16'(sawFlg));
		chk("trap len", 16'h0002, 16'(gotLen));
		chk("trap cyc", 16'h0006, 16'(gotCyc));
	endtask
	task automatic t_lengths;
		logic [3:0] nib;
		logic [2:0] eLen;
		logic [3:0] eCyc;
		for (int i = 2; i < 10; i++) begin
			nib = 4'(i);
			eLen = (nib < 4'h4) ? 3'h2 : (nib < 4'h8) ? 3'h3 : 3'h4;
			eCyc = (nib == 4'h3 || nib == 4'h5 || nib == 4'h7) ? 4'h4 : 4'h3;
			run({4'h7, nib}, 8'h00, 8'h00, 8'h00, 8'h00);
			chk("test len", 16'(eLen), 16'(gotLen));
			chk("test cyc", 16'(eCyc), 16'(gotCyc));
			run({4'hb, nib}, 8'h00, 8'h00, 8'h00, 8'h00);
			chk("xor len", 16'(eLen), 16'(gotLen));
			chk("xor cyc", 16'(eCyc), 16'(gotCyc));
		end
		run(8'h5f, 8'h00, 8'h00, 8'h00, 8'h00);
		chk("illegal", 16'h0001, 16'(sawIll));
		chk("illegal len", 16'h0000, 16'(gotLen));
		chk("illegal busy", 16'h0000, 16'(sawBusy));
	endtask
	task automatic t_pair;
		i_mem.dataMem[16'h0106] = 8'hbe;
		i_mem.dataMem[16'h0107] = 8'hef;
		idle();
		@(posedge ref_clk);
		pairSel <= 3'h3;
		pairReq <= 1'b1;
		@(posedge ref_clk);
		pairReq <= 1'b0;
		for (int k = 0; k < 10; k++) begin
			#1;
			if (pairDone === 1'b1)
				break;
			@(posedge ref_clk);
		end
		chk("pair", 16'hbeef, pairPtr);
	endtask
	task automatic t_disp;
		@(posedge ref_clk);
		dispBase <= 16'h1000;
		dispByte <= 8'hfe;
		@(posedge ref_clk);
		dispByte <= 8'h7f;
		#1 chk("disp neg", 16'h0ffe, dispAddr);
		@(posedge ref_clk);
		dispByte <= 8'hff;
		#1 chk("disp pos", 16'h107f, dispAddr);
		@(posedge ref_clk);
		#1 chk("disp minus one", 16'h0fff, dispAddr);
	endtask
	// ==========
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{instrValid, pairReq, pairSel} = 5'h00;
		{opcode, op1, op2, op3, workBase, flagsIn, dispByte} = 56'h0;
		{pcIn, spIn, dispBase} = 48'h0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		workBase <= 8'h10;
		t_xor();
		t_test();
		t_trap();
		t_pair();
		t_disp();
		t_lengths();
		complete_run();
	end
	// sized well above the whole sequence, far below the run budget
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
endmodule
